// ---- csd_chip_select.sv ----
// Added by the designer: the APB slave port and the register addresses.
`default_nettype none
module csd_chip_select (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire csd_pkg::csd_apb_req_t apb_req,
  output      csd_pkg::csd_apb_rsp_t apb_rsp,
  input  wire csd_pkg::csd_access_t  acc,
  input  wire logic                  int_owned,
  input  wire logic                  int_iack,
  input  wire logic                  slow_bus_clock,
  output logic [11:0]                select_n,
  output logic [11:0]                pin_n,
  output logic [11:0]                alt_func_en,
  output logic                       transfer_ack_n,
  output logic                       autovector_n
);
  csd_pkg::csd_state_t s;
  csd_pkg::csd_state_t next_s;
  logic [11:0] hit;
  logic [11:0] auto_vector_select_hit;
  logic        iack_cyc;
  logic        slow_bus_clock_rise;
  logic        pick_ok;
  logic [3:0]  pick_code;
  logic [3:0]  reg_idx;
  logic        idx_ok;
  logic        in_base;
  logic        in_opt;
  logic        in_pa;
  logic        in_latch;
  logic        mapped;
  logic        wr_en;
  logic [31:0] rd_word;
  logic [11:0] latch_at_pin;

  // address-match per channel; channels never see each other
  assign iack_cyc = acc.fc == csd_pkg::FC_CPU && acc.addr[19:16] == csd_pkg::IACK_TYPE;

  for (genvar i = 0; i < csd_pkg::NCH; i++)
  begin : g_ch
    logic [15:0] b;
    logic [15:0] o;
    logic [1:0]  pa;
    logic [12:0] m;
    logic        addr_ok;
    logic        space_ok;
    logic        rw_ok;
    logic        byte_ok;
    logic        lane_lo;
    logic        lane_hi;
    assign b  = s.base[i];
    assign o  = s.opt[i];
    assign pa = s.pa[2*i +: 2];
    always_comb
    begin
      for (int k = 0; k < 13; k++)
      begin
        m[k] = (k + 11) >= int'(csd_pkg::EXT_LOW[b[2:0]]);
      end
    end
    assign addr_ok = ((acc.addr[23:11] ^ b[15:3]) & m) == 13'h0000;
    always_comb
    begin
      unique case (o[csd_pkg::F_SPACE +: 2])
        csd_pkg::SP_CPU:
          space_ok = acc.fc == csd_pkg::FC_CPU && !int_iack
                     && (o[csd_pkg::F_IPL +: 3] == 3'h0
                         || o[csd_pkg::F_IPL +: 3] == acc.addr[3:1]);
        csd_pkg::SP_USER:
          space_ok = acc.fc != csd_pkg::FC_CPU && !acc.fc[2];
        csd_pkg::SP_SUPV:
          space_ok = acc.fc != csd_pkg::FC_CPU && acc.fc[2];
        default:
          space_ok = acc.fc != csd_pkg::FC_CPU;
      endcase
    end
    assign rw_ok = (o[csd_pkg::F_RW] && acc.rd) || (o[csd_pkg::F_RW + 1] && !acc.rd);
    assign lane_hi = !acc.addr[0];
    assign lane_lo = acc.addr[0] || acc.transfer_size_code != csd_pkg::SIZ_BYTE;
    assign byte_ok = (pa == csd_pkg::PA_8)
                     ? o[csd_pkg::F_BYTE +: 2] != 2'h0
                     : (o[csd_pkg::F_BYTE] && lane_lo)
                       || (o[csd_pkg::F_BYTE + 1] && lane_hi);
    assign hit[i] = acc.as && !int_owned && addr_ok && space_ok && rw_ok && byte_ok;
    assign auto_vector_select_hit[i] = hit[i] && o[csd_pkg::F_AUTO_VECTOR_SELECT];
  end

  assign slow_bus_clock_rise = slow_bus_clock && !s.slow_bus_clock_d;
  assign latch_at_pin = {2'b00, s.latch, 3'b000};

  // lowest-numbered asynchronous channel with internal ack wins
  always_comb
  begin
    pick_ok = 1'b0;
    pick_code = 4'h0;
    for (int i = csd_pkg::NCH - 1; i >= 0; i--)
    begin
      if (hit[i] && !s.opt[i][csd_pkg::F_MODE]
          && s.opt[i][csd_pkg::F_ACK +: 4] != csd_pkg::ACK_EXT)
      begin
        pick_ok = 1'b1;
        pick_code = s.opt[i][csd_pkg::F_ACK +: 4];
      end
    end
  end

  // register decode
  assign reg_idx  = apb_req.paddr[5:2];
  assign idx_ok   = reg_idx < 4'hC && apb_req.paddr[1:0] == 2'b00;
  assign in_base  = apb_req.paddr[7:6] == csd_pkg::OFS_BASE[7:6] && idx_ok;
  assign in_opt   = apb_req.paddr[7:6] == csd_pkg::OFS_OPT[7:6] && idx_ok;
  assign in_pa    = apb_req.paddr == csd_pkg::OFS_PA;
  assign in_latch = apb_req.paddr == csd_pkg::OFS_LATCH;
  assign mapped   = in_base || in_opt || in_pa || in_latch;
  assign wr_en    = apb_req.psel && apb_req.penable && apb_req.pwrite && mapped;

  always_comb
  begin
    rd_word = 32'h00000000;
    if (in_base)
    begin
      rd_word = {16'h0000, s.base[reg_idx]};
    end
    else if (in_opt)
    begin
      rd_word = {16'h0000, s.opt[reg_idx]};
    end
    else if (in_pa)
    begin
      rd_word = {8'h00, s.pa};
    end
    else if (in_latch)
    begin
      rd_word = {25'h0000000, s.latch};
    end
  end

  always_comb
  begin
    next_s = s;
    next_s.slow_bus_clock_d = slow_bus_clock;
    next_s.cyc = acc.as;
    // read data is captured in the setup phase and held through access
    if (apb_req.psel && !apb_req.penable)
    begin
      next_s.prdata = apb_req.pwrite ? 32'h00000000 : rd_word;
      next_s.pslverr = !mapped;
    end
    if (wr_en)
    begin
      if (in_base)
      begin
        next_s.base[reg_idx] = apb_req.pwdata[15:0];
      end
      else if (in_opt)
      begin
        next_s.opt[reg_idx] = apb_req.pwdata[15:0];
      end
      else if (in_pa)
      begin
        next_s.pa = apb_req.pwdata[23:0];
      end
      else
      begin
        next_s.latch = apb_req.pwdata[6:0];
      end
    end
    for (int i = 0; i < csd_pkg::NCH; i++)
    begin
      if (s.opt[i][csd_pkg::F_MODE])
      begin
        next_s.sync_on[i] = hit[i] && (s.sync_on[i] || slow_bus_clock_rise);
        next_s.sel_n[i] = !next_s.sync_on[i];
      end
      else
      begin
        next_s.sync_on[i] = 1'b0;
        next_s.sel_n[i] = !(hit[i]
                            && (s.opt[i][csd_pkg::F_STROBE_SELECT] ? acc.ds : acc.as));
      end
      if (s.pa[2*i + 1])
      begin
        next_s.pin_n[i] = next_s.sel_n[i];
      end
      else if (s.pa[2*i +: 2] == csd_pkg::PA_DISC && csd_pkg::DISC_PINS[i])
      begin
        next_s.pin_n[i] = latch_at_pin[i];
      end
      else
      begin
        next_s.pin_n[i] = 1'b1;
      end
    end
    // internal acknowledge with programmed waits
    if (!acc.as)
    begin
      next_s.ack_arm = 1'b0;
      next_s.ack = 1'b0;
    end
    else if (!s.cyc)
    begin
      if (pick_ok && pick_code == csd_pkg::ACK_FAST)
      begin
        next_s.ack = 1'b1;
      end
      else if (pick_ok)
      begin
        next_s.ack_arm = 1'b1;
        next_s.wcnt = 4'h0;
        next_s.wtgt = pick_code;
      end
    end
    else if (s.ack_arm)
    begin
      if (s.wcnt == s.wtgt)
      begin
        next_s.ack = 1'b1;
        next_s.ack_arm = 1'b0;
      end
      else
      begin
        next_s.wcnt = s.wcnt + 4'h1;
      end
    end
    next_s.auto_vector_select = iack_cyc && |auto_vector_select_hit;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '{base:    {csd_pkg::RST_BOOT_BASE, {11{csd_pkg::RST_BASE}}},
             opt:     {csd_pkg::RST_BOOT_OPT, {11{csd_pkg::RST_OPT}}},
             pa:      csd_pkg::RST_PA,
             latch:   7'h00,
             prdata:  32'h00000000,
             pslverr: 1'b0,
             sel_n:   12'hFFF,
             sync_on: 12'h000,
             pin_n:   12'hFFF,
             slow_bus_clock_d:  1'b0,
             cyc:     1'b0,
             ack_arm: 1'b0,
             wcnt:    4'h0,
             wtgt:    4'h0,
             ack:     1'b0,
             auto_vector_select:    1'b0};
    end
    else if (ce)
    begin
      s <= next_s;
    end
  end

  assign apb_rsp.prdata  = s.prdata;
  assign apb_rsp.pslverr = s.pslverr;
  assign apb_rsp.pready  = ce;
  assign select_n        = s.sel_n;
  assign pin_n           = s.pin_n;
  assign transfer_ack_n  = !s.ack;
  assign autovector_n    = !s.auto_vector_select;
  for (genvar i = 0; i < csd_pkg::NCH; i++)
  begin : g_alt
    assign alt_func_en[i] = s.pa[2*i +: 2] == csd_pkg::PA_ALT;
  end

  // checks
  boot_reset_a: assert property (@(posedge clk)
    $rose(rst_n) |-> s.base[csd_pkg::BOOT] == 16'h0006)
    else $error("boot base reset wrong");
  boot_bytes_a: assert property (@(posedge clk)
    $rose(rst_n) |-> s.opt[csd_pkg::BOOT][14:13] == 2'h3 && s.opt[0][14:13] == 2'h0)
    else $error("byte lane reset wrong");
  sel_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    (select_n != 12'hFFF) |-> $past(|hit))
    else $error("select without match");
  owned_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && int_owned |=> select_n == 12'hFFF)
    else $error("select on internal address");
  async_as_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && hit[0] && !s.opt[0][15] && !s.opt[0][10] |=> !select_n[0])
    else $error("async select late");
  sync_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s.sync_on[0]) |-> $past(slow_bus_clock_rise))
    else $error("sync select off edge");
  wait_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && acc.as && s.ack_arm && s.wcnt == s.wtgt |=> !transfer_ack_n)
    else $error("wait ack missed");
  wait_early_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(transfer_ack_n) |-> $past(s.ack_arm) || $past(pick_code) == 4'hE)
    else $error("ack came early");
  iack_int_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && int_iack && acc.fc == 3'h7 |=> autovector_n)
    else $error("autovector on internal iack");
  auto_vector_select_term_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && iack_cyc && |auto_vector_select_hit |=> !autovector_n)
    else $error("autovector missing");
  latch_bit7_a: assert property (@(posedge clk) disable iff (!rst_n)
    apb_req.psel && apb_req.penable && in_latch |-> apb_rsp.prdata[31:7] == 25'h0)
    else $error("latch high bits set");

  async_sel_c: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(select_n[0]) && !s.opt[0][15]);
  sync_sel_c: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(select_n[1]) && s.opt[1][15]);
  wait_ack_c: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(transfer_ack_n) && s.wtgt == 4'h3);
  auto_vector_select_c: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(autovector_n));
endmodule
`default_nettype wire

// ---- csd_pkg.sv ----
// Contract
// - block_extent codes 000..111 pick 2K..1M blocks, compare ADDR[23:11]..ADDR[23:20].
// - boot base resets to zero with a 512 Kbyte block.
// - mode bit: 0 asynchronous assertion, 1 aligned to slow_bus_clock.
// - 8-bit port: any nonzero byte lanes enable; 16-bit port: lanes select transfers.
// - 16-bit port matches address bit zero and transfer_size_code against byte lanes.
// - general byte lanes reset disabled; boot byte lanes reset to both.
// - read_write_qualifier: 01 reads, 10 writes, 11 both, 00 reserved.
// - asynchronous mode: strobe_select times select to address or data strobe.
// - acknowledge field: 0..13 wait states, 1110 fast, 1111 external.
// - space field: 00 CPU, 01 user, 10 supervisor, 11 either.
// - CPU space compares ADDR[3:1] with priority_match_level; 000 matches any.
// - auto_vector_select requests internal autovector on external interrupt acknowledge.
// - internal module interrupt acknowledge gets no select, ack or autovector.
// - latch bits 6..0 drive select pins 9..3 as discrete outputs; bit7 zero.
// - select asserts with the chosen strobe, or aligned to slow_bus_clock.
// - without internal ack the cycle waits for the peripheral's transfer_ack.
// - base bits 15..3 compare with ADDR[23:11], also in CPU space.
// - internal autovector terminates the interrupt acknowledge cycle.
// - channel blocks may overlap; every channel matches independently.
// - pin_assignment: 00 discrete, 01 alternate, 10 8-bit select, 11 16-bit select.
// - selects are active low; internally owned addresses assert none.
// - matching continues on discrete or alternate pins for ack and autovector.
`default_nettype none
package csd_pkg;
  localparam int NCH  = 12;
  localparam int BOOT = 11;
  localparam logic [7:0] OFS_BASE  = 8'h00;
  localparam logic [7:0] OFS_OPT   = 8'h40;
  localparam logic [7:0] OFS_PA    = 8'h80;
  localparam logic [7:0] OFS_LATCH = 8'h84;
  localparam int F_MODE  = 15;
  localparam int F_BYTE  = 13;
  localparam int F_RW    = 11;
  localparam int F_STROBE_SELECT  = 10;
  localparam int F_ACK   = 6;
  localparam int F_SPACE = 4;
  localparam int F_IPL   = 1;
  localparam int F_AUTO_VECTOR_SELECT  = 0;
  localparam logic [15:0] RST_BASE      = 16'h0000;
  localparam logic [15:0] RST_BOOT_BASE = 16'h0006;
  localparam logic [15:0] RST_OPT       = 16'h0000;
  localparam logic [15:0] RST_BOOT_OPT  = 16'h7B70;
  localparam logic [23:0] RST_PA        = 24'hFFFFFF;
  localparam logic [7:0][4:0] EXT_LOW = {5'h14, 5'h13, 5'h12, 5'h11,
                                         5'h10, 5'h0E, 5'h0D, 5'h0B};
  localparam logic [3:0] ACK_FAST  = 4'hE;
  localparam logic [3:0] ACK_EXT   = 4'hF;
  localparam logic [2:0] FC_CPU    = 3'h7;
  localparam logic [3:0] IACK_TYPE = 4'hF;
  localparam logic [1:0] SP_CPU    = 2'h0;
  localparam logic [1:0] SP_USER   = 2'h1;
  localparam logic [1:0] SP_SUPV   = 2'h2;
  localparam logic [1:0] PA_DISC   = 2'h0;
  localparam logic [1:0] PA_ALT    = 2'h1;
  localparam logic [1:0] PA_8      = 2'h2;
  localparam logic [1:0] SIZ_BYTE  = 2'h1;
  localparam logic [11:0] DISC_PINS = 12'h3F8;

  typedef struct packed {
    logic [23:0] addr;
    logic [2:0]  fc;
    logic        rd;
    logic [1:0]  transfer_size_code;
    logic        as;
    logic        ds;
  } csd_access_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } csd_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } csd_apb_rsp_t;

  typedef struct packed {
    logic [NCH-1:0][15:0] base;
    logic [NCH-1:0][15:0] opt;
    logic [2*NCH-1:0]     pa;
    logic [6:0]           latch;
    logic [31:0]          prdata;
    logic                 pslverr;
    logic [NCH-1:0]       sel_n;
    logic [NCH-1:0]       sync_on;
    logic [NCH-1:0]       pin_n;
    logic                 slow_bus_clock_d;
    logic                 cyc;
    logic                 ack_arm;
    logic [3:0]           wcnt;
    logic [3:0]           wtgt;
    logic                 ack;
    logic                 auto_vector_select;
  } csd_state_t;
endpackage
`default_nettype wire

// ---- csd_periph_model.sv ----
`default_nettype none
module csd_periph_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sel_n,
  input  wire logic       as,
  input  wire logic [3:0] lat,
  output logic            ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // slow device: acknowledges lat+1 cycles after its select, pull-up level once as drops
  always_ff @(posedge clk)
  begin
    if (!rst_n || !as)
    begin
      cnt   <= 4'h0;
      ack_n <= 1'b1;
    end
    else if (!sel_n)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == lat)
        ack_n <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- chip_select_decoder_tb_top.sv ----
`default_nettype none
module chip_select_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk;
  logic                  rst_n;
  logic                  sbc;
  logic                  own;
  logic                  iack;
  logic                  pack_n;
  logic [3:0]            lat;
  logic [11:0]           sel_n;
  logic [11:0]           pin_n;
  logic [11:0]           alt;
  logic [11:0]           s1;
  logic                  ack_n;
  logic                  av_n;
  logic [31:0]           rd;
  logic                  er;
  logic [31:0]           mdl [logic [7:0]];
  csd_pkg::csd_apb_req_t req;
  csd_pkg::csd_apb_rsp_t rsp;
  csd_pkg::csd_access_t  acc;
  int                    n_fail;
  int                    comparisons;
  int                    sk;
  int                    ak;
  int                    vk;
  int                    pk;
  int                    shv [8] = '{11, 13, 14, 16, 17, 18, 19, 20};

  csd_chip_select i_csd_chip_select (.clk(clk), .rst_n(rst_n), .ce(1'b1), .apb_req(req),
    .apb_rsp(rsp), .acc(acc), .int_owned(own), .int_iack(iack), .slow_bus_clock(sbc),
    .select_n(sel_n), .pin_n(pin_n), .alt_func_en(alt), .transfer_ack_n(ack_n),
    .autovector_n(av_n));
  csd_periph_model i_csd_periph_model (.clk(clk), .rst_n(rst_n), .sel_n(pin_n[2]),
    .as(acc.as), .lat(lat), .ack_n(pack_n));

  always #12.5 clk = ~clk;

  task automatic print_verdict();
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  function automatic logic [7:0] ba(int i);
    return csd_pkg::OFS_BASE + 8'(4 * i);
  endfunction

  function automatic logic [7:0] oa(int i);
    return csd_pkg::OFS_OPT + 8'(4 * i);
  endfunction

  // reference decode of one channel from its base, option and pin field
  function automatic logic hit(logic [15:0] b, logic [15:0] o, logic [1:0] pf, logic [23:0] a,
                               logic [2:0] f, logic r, logic [1:0] z);
    logic ok;
    ok = (a >> shv[b[2:0]]) == ({b[15:3], 11'h0} >> shv[b[2:0]]);
    ok &= o[12:11] == 2'h3 || (o[12:11] == 2'h1 && r) || (o[12:11] == 2'h2 && !r);
    ok &= (o[5:4] == 2'h0) ? (f == 3'h7 && (o[3:1] == 3'h0 || o[3:1] == a[3:1]))
                           : (f != 3'h7 && (o[5:4] == 2'h3 || f[2] == o[5]));
    ok &= o[14:13] != 2'h0 && (pf == 2'h2 || o[14] || a[0] || z != csd_pkg::SIZ_BYTE);
    ok &= pf == 2'h2 || o[13] || !a[0];
    return ok;
  endfunction

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      n_fail++;
      print_verdict();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // one idle edge keeps the next setup from re-driving psel in this time step
    @(posedge clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(1'b1, a, d);
    if (mdl.exists(a))
      mdl[a] = d & (a == csd_pkg::OFS_LATCH ? 32'h7F
                    : a == csd_pkg::OFS_PA ? 32'hFFFFFF : 32'hFFFF);
  endtask

  task automatic rdc(logic [7:0] a);
    apb(1'b0, a, 32'h0);
    chk("prdata", mdl.exists(a) ? mdl[a] : 32'h0, rd);
    chk("pslverr", {31'h0, !mdl.exists(a)}, {31'h0, er});
  endtask

  // one processor bus cycle: edges to select, ack, autovector and device ack
  task automatic cyc(logic [23:0] a, logic [2:0] f, logic r, logic [1:0] z, int ch);
    acc <= '{a, f, r, z, 1'b1, 1'b1};
    sk = 0;
    ak = 0;
    vk = 0;
    pk = 0;
    for (int k = 1; k < 20; k++)
    begin
      @(posedge clk);
      #1;
      if (k == 1)
        s1 = sel_n;
      if (sk == 0 && sel_n[ch] === 1'b0)
        sk = k;
      if (ak == 0 && ack_n === 1'b0)
        ak = k;
      if (vk == 0 && av_n === 1'b0)
        vk = k;
      if (pk == 0 && pack_n === 1'b0)
        pk = k;
    end
    @(posedge clk);
    acc.as <= 1'b0;
    acc.ds <= 1'b0;
    @(posedge clk);
    #1;
    chk("ack release", 32'h1, {31'h0, ack_n});
    @(posedge clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    logic [15:0] b;
    logic [15:0] o;
    logic [23:0] a;
    logic [23:0] m;
    logic [1:0]  pf;
    logic        ex;
    int          cd [6] = '{0, 1, 7, 13, 14, 15};
    clk = 1'b0;
    rst_n = 1'b0;
    sbc = 1'b0;
    own = 1'b0;
    iack = 1'b0;
    lat = 4'h0;
    req = '0;
    acc = '0;
    n_fail = 0;
    comparisons = 0;
    void'($urandom(32'h5AC5));
    for (int i = 0; i < 12; i++)
    begin
      mdl[ba(i)] = 32'h0;
      mdl[oa(i)] = 32'h0;
    end
    mdl[ba(11)] = 32'h6;
    mdl[oa(11)] = {17'h0, 2'h3, 2'h3, 1'b0, 4'hD, 2'h3, 4'h0};
    mdl[csd_pkg::OFS_PA] = 32'hFFFFFF;
    mdl[csd_pkg::OFS_LATCH] = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cyc(24'h000100, 3'h6, 1'b1, 2'h2, 11);
    chk("boot select", 32'h1, 32'(sk));
    chk("boot wait", 32'h0000000F, 32'(ak));
    chk("idle selects", 32'h7FF, {21'h0, s1[10:0]});
    for (int i = 0; i < 12; i++)
    begin
      rdc(ba(i));
      rdc(oa(i));
    end
    rdc(csd_pkg::OFS_PA);
    for (int i = 0; i < 11; i++)
    begin
      wr(ba(i), $urandom);
      wr(oa(i), $urandom);
      rdc(ba(i));
      rdc(oa(i));
      wr(oa(i), 32'h0);
    end
    wr(8'h30, 32'hFFFF);
    wr(8'h41, 32'hFFFF);
    rdc(8'h30);
    rdc(8'h41);
    rdc(oa(0));
    for (int i = 0; i < 150; i++)
    begin
      b = 16'($urandom);
      o = 16'($urandom);
      o[15] = 1'b0;
      pf = 2'h2 | 2'($urandom % 2);
      m = (24'h1 << shv[b[2:0]]) - 24'h1;
      a = {b[15:3], 11'h0} & ~m;
      b[15:3] = a[23:11];
      a = 24'($urandom);
      if ($urandom % 2)
        a = ({b[15:3], 11'h0} & ~m) | (a & m);
      wr(ba(1), {16'h0, b});
      wr(oa(1), {16'h0, o});
      wr(csd_pkg::OFS_PA, {8'h0, 20'hFFFFF, pf, 2'h3});
      own <= ($urandom % 8 == 0);
      cyc(a, 3'($urandom), 1'($urandom), 2'($urandom), 1);
      ex = hit(b, o, pf, a, acc.fc, acc.rd, acc.transfer_size_code) && !own;
      chk("select", {31'h0, ex}, 32'(sk));
    end
    own <= 1'b0;
    wr(oa(1), 32'h0);
    wr(ba(0), 32'h1007);
    wr(oa(0), 32'h7BF0);
    wr(ba(2), 32'h1007);
    foreach (cd[j])
    begin
      wr(oa(2), 32'h7830 | (cd[j] << 6));
      lat <= 4'(5 * (j % 2));
      cyc({4'h1, 20'($urandom)}, 3'h5, 1'b0, 2'h2, 2);
      chk("ack wait", 32'(cd[j] == 14 ? 1 : cd[j] == 15 ? 0 : cd[j] + 2), 32'(ak));
      chk("device ack", 32'(lat + 2), 32'(pk));
      chk("overlap", 32'h0, {30'h0, s1[2], s1[0]});
    end
    wr(oa(2), 32'hFFF0);
    acc <= '{24'h100000, 3'h5, 1'b1, 2'h2, 1'b1, 1'b0};
    repeat (3) @(posedge clk);
    sbc <= 1'b1;
    #1;
    chk("sync hold", 32'h1, {31'h0, sel_n[2]});
    repeat (2) @(posedge clk);
    #1;
    chk("sync select", 32'h0, {31'h0, sel_n[2]});
    @(posedge clk);
    acc.as <= 1'b0;
    sbc <= 1'b0;
    @(posedge clk);
    wr(oa(2), 32'h7FF0);
    acc <= '{24'h100000, 3'h5, 1'b1, 2'h2, 1'b1, 1'b0};
    repeat (2) @(posedge clk);
    acc.ds <= 1'b1;
    #1;
    chk("strobe wait", 32'h1, {31'h0, sel_n[2]});
    @(posedge clk);
    #1;
    chk("strobe select", 32'h0, {31'h0, sel_n[2]});
    @(posedge clk);
    acc <= '0;
    @(posedge clk);
    wr(csd_pkg::OFS_PA, 32'hD0003F);
    wr(ba(3), 32'hFFFB);
    for (int ip = 0; ip < 8; ip += 5)
      for (int p = 0; p < 8; p++)
      begin
        wr(oa(3), 32'h2BC1 | (ip << 1));
        iack <= ($urandom % 4 == 0);
        cyc({20'hFFFFF, 3'(p), 1'b1}, 3'h7, 1'b1, csd_pkg::SIZ_BYTE, 3);
        chk("iack select", {31'h0, (ip == 0 || p == ip) && !iack}, 32'(sk));
        chk("autovector", {31'h0, (ip == 0 || p == ip) && !iack}, 32'(vk));
      end
    iack <= 1'b0;
    wr(csd_pkg::OFS_LATCH, $urandom);
    rdc(csd_pkg::OFS_LATCH);
    chk("latch pins", {25'h0, mdl[csd_pkg::OFS_LATCH][6:0]}, {25'h0, pin_n[9:3]});
    chk("alt pins", 32'h400, {20'h0, alt});
    print_verdict();
  end
endmodule
`default_nettype wire
